// ===== logic/ashp_pkg.sv
// Shared constants and types for the serial host port and its host controller
package ashp_pkg;
    localparam int          WORD_BITS      = 32;
    localparam logic [5:0]  MIN_WRITE_CLKS = 6'h20;
    localparam logic [7:0]  CMD_WRITE      = 8'hD0;
    localparam logic [7:0]  REG_HOST_IN    = 8'h08;
    localparam logic [7:0]  REG_OUT_CTL    = 8'h0C;
    localparam logic [7:0]  REG_DATA_CTL   = 8'h10;
    localparam int          HPS_LSB        = 0;
    localparam int          RPS_LSB        = 0;
    localparam int          SCS_BIT        = 6;
    localparam int          SLC_LSB        = 8;
    localparam int          CHAIN_BIT      = 0;
    localparam int          SUPPLY_BIT     = 1;
    localparam int          INPUT_BIT      = 2;
    localparam int          RANGE_BIT      = 3;
    localparam int          PARITY_BIT     = 4;
    localparam logic [1:0]  PROTO_RST      = 2'h0;
    localparam logic [1:0]  READ_SPI       = 2'h0;
    localparam logic [1:0]  DUAL_LANE      = 2'h3;
    localparam logic [1:0]  LANE_CFG_RST   = 2'h0;
    localparam logic [4:0]  DATA_CTL_RST   = 5'h00;
    localparam int          INT_HALF       = 4;
    localparam int          SCLK_HALF      = 8;
    localparam logic [3:0]  HREG_TX        = 4'h0;
    localparam logic [3:0]  HREG_CFG       = 4'h1;
    localparam logic [3:0]  HREG_GO        = 4'h2;
    localparam logic [3:0]  HREG_STAT      = 4'h3;
    localparam logic [3:0]  HREG_RX        = 4'h4;
    localparam int          HCFG_DUAL      = 2;
    localparam int          HCFG_STROBE    = 3;
    localparam int          HCFG_NOCLK     = 4;
    localparam int          HCFG_CLKS_LSB  = 8;
    localparam logic [5:0]  HCFG_CLKS_RST  = 6'h20;

    typedef enum logic [1:0] {
        PROTO_00 = 2'b00,
        PROTO_01 = 2'b01,
        PROTO_10 = 2'b10,
        PROTO_11 = 2'b11
    } ashp_proto_t;
endpackage

// ===== logic/ashp_link_if.sv
// Serial link between the host controller and the converter host port
`timescale 1ns/10ps
interface ashp_link_if;
    logic convert_start_select_n;
    logic serial_clock;
    logic serial_in;
    logic serial_out_lane0;
    logic shared_alarm_pin;
    logic ready_strobe_out;

    modport device (
        input  convert_start_select_n,
        input  serial_clock,
        input  serial_in,
        output serial_out_lane0,
        output shared_alarm_pin,
        output ready_strobe_out
    );
    modport host (
        output convert_start_select_n,
        output serial_clock,
        output serial_in,
        input  serial_out_lane0,
        input  shared_alarm_pin,
        input  ready_strobe_out
    );
endinterface

// ===== logic/ashp_device.sv
// Converter serial host port: configuration writes, output word build and lane shifting
//
// Contract
// - Word layout: result, supply alarm, range, parity
// - Host may use any of four protocols
// - Codes 0..3 select polarity and capture edge
// - Reset returns to mode 0
// - Host changes protocol using mode 0
// - Selected protocol governs reads and writes
// - Writes need at least 32 clocks
// - First bit launch depends on mode
// - Read select 00b uses SPI protocol
// - Strobe stays low in SPI reads
// - Short frames are tolerated
// - Long frame with zero control chains
// - Lane config 11b enables second lane
// - Dual lane drives two bits per edge
// - Dual lane keeps same edge timing
// - Source-sync reads drive strobe clock
// - Source select picks host or internal clock
// - Writes always SPI; reads may be sync
// - Command applies at chip-select rise
// - Frame F command shapes frame F+1
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module ashp_device (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [17:0] conv_result,
    input  wire logic [1:0]  supply_alarm,
    input  wire logic [1:0]  input_alarm,
    input  wire logic [3:0]  range_code,
    input  wire logic [3:0]  chain_id,
    input  wire logic        alarm_level,
    output logic [1:0]       host_protocol_sel,
    output logic [1:0]       read_protocol_sel,
    output logic [1:0]       second_lane_cfg,
    output logic             sync_clock_source_sel,
    output logic [4:0]       data_ctl,
    ashp_link_if.device      link
);
    import ashp_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SPI  = 2'b01,
        ST_INT  = 2'b10
    } ashp_dev_state_t;

    ashp_dev_state_t state;
    logic            cs_s1, cs_s2, cs_s3;
    logic            ck_s1, ck_s2, ck_s3;
    logic            di_s1, di_s2;
    logic [31:0]     rx_word;
    logic [5:0]      clk_count;
    logic [31:0]     tx;
    logic [31:0]     next_tx;
    logic            first_pending;
    logic            next_first;
    logic            chain_bit;
    logic            driving;
    logic            next_driving;
    logic [2:0]      int_div;
    logic [5:0]      int_left;
    logic            int_strobe;
    logic            lane0;
    logic            lane1_or_alarm;
    logic            strobe;

    logic cs_fall, cs_rise, active, ck_rise, ck_fall;
    logic cap_rising, cap_edge, launch_edge, late, dual, chain_mode, src_mode;
    logic int_tick, shift_now;

    // Pins cross through two flops; edges are judged on the second and third stages only
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            di_s1 <= 1'b0;
            di_s2 <= 1'b0;
        end else begin
            cs_s1 <= link.convert_start_select_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            ck_s1 <= link.serial_clock;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            di_s1 <= link.serial_in;
            di_s2 <= di_s1;
        end
    end

    assign cs_fall     = cs_s3 & ~cs_s2;
    assign cs_rise     = ~cs_s3 & cs_s2;
    assign active      = ~cs_s2;
    assign ck_rise     = active & ~ck_s3 & ck_s2;
    assign ck_fall     = active & ck_s3 & ~ck_s2;
    assign cap_rising  = ~(host_protocol_sel[0] ^ host_protocol_sel[1]);
    assign cap_edge    = cap_rising ? ck_rise : ck_fall;
    assign launch_edge = cap_rising ? ck_fall : ck_rise;
    assign late        = host_protocol_sel[0];
    assign dual        = (second_lane_cfg == DUAL_LANE);
    assign src_mode    = (read_protocol_sel != READ_SPI);
    assign chain_mode  = ~src_mode & (second_lane_cfg == LANE_CFG_RST) & ~sync_clock_source_sel;
    assign int_tick    = (state == ST_INT) & (int_div == 3'(INT_HALF - 1));
    assign shift_now   = (state == ST_INT) ? (int_tick & int_strobe & (int_left != 6'h00))
                                           : launch_edge;

    // Flags are appended in fixed order; whatever is left below stays zero
    function automatic logic [31:0] build_word(input logic [4:0] ctl);
        logic [31:0] w;
        logic [5:0]  len;
        w   = {14'h0000, conv_result};
        len = 6'd18;
        if (ctl[CHAIN_BIT]) begin
            w   = {w[27:0], chain_id};
            len = len + 6'd4;
        end
        if (ctl[SUPPLY_BIT]) begin
            w   = {w[29:0], supply_alarm};
            len = len + 6'd2;
        end
        if (ctl[INPUT_BIT]) begin
            w   = {w[29:0], input_alarm};
            len = len + 6'd2;
        end
        if (ctl[RANGE_BIT]) begin
            w   = {w[27:0], range_code};
            len = len + 6'd4;
        end
        if (ctl[PARITY_BIT]) begin
            w   = {w[29:0], ^conv_result, ^w};
            len = len + 6'd2;
        end
        build_word = w << (6'd32 - len);
    endfunction

    // Configuration takes effect only when the frame closes, so the frame in flight never changes mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            host_protocol_sel     <= PROTO_RST;
            read_protocol_sel     <= READ_SPI;
            second_lane_cfg       <= LANE_CFG_RST;
            sync_clock_source_sel <= 1'b0;
            data_ctl              <= DATA_CTL_RST;
        end else if (cs_rise && clk_count >= MIN_WRITE_CLKS && rx_word[31:24] == CMD_WRITE) begin
            unique case (rx_word[23:16])
                REG_HOST_IN: host_protocol_sel <= rx_word[HPS_LSB +: 2];
                REG_OUT_CTL: begin
                    read_protocol_sel     <= rx_word[RPS_LSB +: 2];
                    second_lane_cfg       <= rx_word[SLC_LSB +: 2];
                    sync_clock_source_sel <= rx_word[SCS_BIT];
                end
                REG_DATA_CTL: data_ctl <= rx_word[4:0];
                default: ;
            endcase
        end
    end

    // Input side: writes always follow the selected clock protocol
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rx_word   <= 32'h0000_0000;
            clk_count <= 6'h00;
            chain_bit <= 1'b0;
        end else if (cs_fall) begin
            clk_count <= 6'h00;
        end else if (cap_edge) begin
            rx_word   <= {rx_word[30:0], di_s2};
            chain_bit <= di_s2;
            if (clk_count != 6'h3F) begin
                clk_count <= clk_count + 6'h01;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= ST_IDLE;
        end else if (cs_rise) begin
            state <= ST_IDLE;
        end else if (cs_fall) begin
            state <= (src_mode && sync_clock_source_sel) ? ST_INT : ST_SPI;
        end
    end

    // Internal clock for source-sync reads; data moves on the strobe's falling half
    always_ff @(posedge sys_clk) begin
        if (sys_rst || state != ST_INT) begin
            int_div    <= 3'h0;
            int_strobe <= 1'b0;
            int_left   <= dual ? 6'(WORD_BITS / 2) : 6'(WORD_BITS);
        end else if (int_tick) begin
            int_div <= 3'h0;
            if (int_left != 6'h00) begin
                int_strobe <= ~int_strobe;
                if (int_strobe) begin
                    int_left <= int_left - 6'h01;
                end
            end
        end else begin
            int_div <= int_div + 3'h1;
        end
    end

    always_comb begin
        next_tx      = tx;
        next_first   = first_pending;
        next_driving = driving;
        if (cs_fall) begin
            next_tx      = build_word(data_ctl);
            next_first   = late & ~(src_mode & sync_clock_source_sel);
            next_driving = ~next_first;
        end else if (!active) begin
            next_driving = 1'b0;
        end else if (shift_now) begin
            if (first_pending && state == ST_SPI) begin
                next_first   = 1'b0;
                next_driving = 1'b1;
            end else if (dual) begin
                next_tx = {tx[29:0], 2'b00};
            end else begin
                next_tx = {tx[30:0], chain_mode & chain_bit};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx            <= 32'h0000_0000;
            first_pending <= 1'b0;
            driving       <= 1'b0;
        end else begin
            tx            <= next_tx;
            first_pending <= next_first;
            driving       <= next_driving;
        end
    end

    // Lane 1 carries the odd bit ahead of lane 0 in dual mode
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lane0          <= 1'b0;
            lane1_or_alarm <= 1'b0;
            strobe         <= 1'b0;
        end else begin
            lane0          <= next_driving & (dual ? next_tx[30] : next_tx[31]);
            lane1_or_alarm <= dual ? (next_driving & next_tx[31]) : alarm_level;
            if (!active || !src_mode) begin
                strobe <= 1'b0;
            end else if (state == ST_INT) begin
                strobe <= int_strobe;
            end else begin
                strobe <= ~next_first & (ck_s2 == cap_rising);
            end
        end
    end

    assign link.serial_out_lane0 = lane0;
    assign link.shared_alarm_pin = lane1_or_alarm;
    assign link.ready_strobe_out = strobe;
endmodule

// ===== logic/ashp_host.sv
// Host controller that frames writes and reads on the converter's serial link
`timescale 1ns/10ps
module ashp_host #(
    parameter int HALF_CYCLES = ashp_pkg::SCLK_HALF
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    ashp_link_if.host        link
);
    import ashp_pkg::*;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_RUN  = 2'b01,
        H_HOLD = 2'b10
    } ashp_host_state_t;

    ashp_host_state_t state;
    logic [31:0]      tx_word, tx_sh, rx_word;
    logic [1:0]       proto;
    logic             dual, use_strobe, no_clock;
    logic [5:0]       clocks;
    logic [6:0]       edges_left;
    logic [7:0]       div;
    logic             first;
    logic             cs_n, sck, sdi;
    logic             l0_s1, l0_s2, l1_s1, l1_s2, st_s1, st_s2, st_s3;
    logic             half_done, cap_rising, new_level, is_capture, stb_rise;

    assign cap_rising = ~(proto[0] ^ proto[1]);
    assign half_done  = (div == 8'(HALF_CYCLES - 1));
    assign new_level  = ~sck;
    assign is_capture = (new_level == cap_rising);
    assign stb_rise   = ~cs_n & st_s2 & ~st_s3;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            l0_s1 <= 1'b0;
            l0_s2 <= 1'b0;
            l1_s1 <= 1'b0;
            l1_s2 <= 1'b0;
            st_s1 <= 1'b0;
            st_s2 <= 1'b0;
            st_s3 <= 1'b0;
        end else begin
            l0_s1 <= link.serial_out_lane0;
            l0_s2 <= l0_s1;
            l1_s1 <= link.shared_alarm_pin;
            l1_s2 <= l1_s1;
            st_s1 <= link.ready_strobe_out;
            st_s2 <= st_s1;
            st_s3 <= st_s2;
        end
    end

    // Settings apply to the next frame; the host must itself send the mode change in mode 0
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            tx_word    <= 32'h0000_0000;
            proto      <= PROTO_RST;
            dual       <= 1'b0;
            use_strobe <= 1'b0;
            no_clock   <= 1'b0;
            clocks     <= HCFG_CLKS_RST;
        end else if (wr && state == H_IDLE) begin
            if (addr == HREG_TX) begin
                tx_word <= wdata;
            end
            if (addr == HREG_CFG) begin
                proto      <= wdata[1:0];
                dual       <= wdata[HCFG_DUAL];
                use_strobe <= wdata[HCFG_STROBE];
                no_clock   <= wdata[HCFG_NOCLK];
                clocks     <= wdata[HCFG_CLKS_LSB +: 6];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state      <= H_IDLE;
            cs_n       <= 1'b1;
            sck        <= 1'b0;
            sdi        <= 1'b0;
            div        <= 8'h00;
            edges_left <= 7'h00;
            first      <= 1'b0;
            tx_sh      <= 32'h0000_0000;
            rx_word    <= 32'h0000_0000;
        end else begin
            unique case (state)
                H_IDLE: begin
                    sck <= proto[1];
                    div <= 8'h00;
                    if (wr && addr == HREG_GO) begin
                        state      <= H_RUN;
                        cs_n       <= 1'b0;
                        tx_sh      <= tx_word;
                        sdi        <= proto[0] ? 1'b0 : tx_word[31];
                        first      <= proto[0];
                        edges_left <= {clocks, 1'b0};
                        // Old capture dropped so a short frame reads back clean
                        rx_word    <= 32'h0000_0000;
                    end
                end
                H_RUN: begin
                    div <= half_done ? 8'h00 : div + 8'h01;
                    if (half_done) begin
                        if (edges_left == 7'h00) begin
                            state <= H_HOLD;
                        end else begin
                            edges_left <= edges_left - 7'h01;
                            if (!no_clock) begin
                                sck <= new_level;
                                if (is_capture && !use_strobe) begin
                                    rx_word <= dual ? {rx_word[29:0], l1_s2, l0_s2} : {rx_word[30:0], l0_s2};
                                end else if (!is_capture && first) begin
                                    first <= 1'b0;
                                    sdi   <= tx_sh[31];
                                end else if (!is_capture) begin
                                    tx_sh <= {tx_sh[30:0], 1'b0};
                                    sdi   <= tx_sh[30];
                                end
                            end
                        end
                    end
                    if (use_strobe && stb_rise) begin
                        rx_word <= dual ? {rx_word[29:0], l1_s2, l0_s2} : {rx_word[30:0], l0_s2};
                    end
                end
                H_HOLD: begin
                    div <= half_done ? 8'h00 : div + 8'h01;
                    if (half_done) begin
                        cs_n  <= 1'b1;
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                HREG_TX:   rdata <= tx_word;
                HREG_CFG:  rdata <= {18'h0_0000, clocks, 3'h0, no_clock, use_strobe, dual, proto};
                HREG_STAT: rdata <= {31'h0000_0000, state != H_IDLE};
                HREG_RX:   rdata <= rx_word;
                default:   rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    assign link.convert_start_select_n = cs_n;
    assign link.serial_clock           = sck;
    assign link.serial_in              = sdi;
endmodule

// ===== tb/ashp_link_asserts.sv
// Link checks for the converter serial host port
`timescale 1ns/10ps
module ashp_link_asserts (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic       convert_start_select_n,
    input wire logic       serial_clock,
    input wire logic       serial_in,
    input wire logic       serial_out_lane0,
    input wire logic       shared_alarm_pin,
    input wire logic       ready_strobe_out,
    input wire logic [1:0] host_protocol_sel,
    input wire logic [1:0] read_protocol_sel,
    input wire logic [1:0] second_lane_cfg
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Launch-edge checks skip select high: the synchroniser lag lets the last bit linger there
    launch_edge_a: assert property (($changed(serial_out_lane0) && !convert_start_select_n
        && read_protocol_sel == 2'h0) |-> serial_clock == ^host_protocol_sel)
        else $error("lane 0 changed off the launch level");
    dual_edge_a: assert property (($changed(shared_alarm_pin) && !convert_start_select_n
        && second_lane_cfg == 2'h3 && read_protocol_sel == 2'h0) |-> serial_clock == ^host_protocol_sel)
        else $error("lane 1 changed off the launch level");
    strobe_low_a: assert property (read_protocol_sel == 2'h0 |-> !ready_strobe_out)
        else $error("strobe moved in a plain read");
    strobe_idle_a: assert property (convert_start_select_n [*8] |-> !ready_strobe_out)
        else $error("strobe active outside a frame");
    cfg_at_rise_a: assert property ($changed(host_protocol_sel) |-> convert_start_select_n)
        else $error("protocol changed inside a frame");
    reset_mode_a: assert property ($fell(sys_rst) |-> host_protocol_sel == 2'h0
        && read_protocol_sel == 2'h0 && second_lane_cfg == 2'h0)
        else $error("port not in mode 0 after reset");
    clk_polarity_a: assert property ($fell(convert_start_select_n) |-> serial_clock == host_protocol_sel[1])
        else $error("clock idle level wrong at frame start");
    lane0_idle_a: assert property (convert_start_select_n [*8] |-> !serial_out_lane0)
        else $error("lane 0 active outside a frame");
    lane1_idle_a: assert property ((second_lane_cfg == 2'h3 && convert_start_select_n) [*8]
        |-> !shared_alarm_pin)
        else $error("lane 1 active outside a frame");
    cover property (second_lane_cfg == 2'h3 && $fell(convert_start_select_n));
    cover property ($rose(ready_strobe_out));
    cover property ($changed(host_protocol_sel));
endmodule

// ===== tb/ashp_bench.sv
// Self-checking bench joining the host controller to the converter port
`timescale 1ns/10ps
module ashp_bench;
    import ashp_pkg::*;
    logic        sys_clk = '0;
    logic        sys_rst = '1;
    logic [3:0]  addr = '0;
    logic [31:0] wdata = '0;
    logic        wr = '0;
    logic        rd = '0;
    logic        rx_q = '0;
    logic [31:0] rdata;
    logic [17:0] res = '0;
    logic [1:0]  sa = '0;
    logic [1:0]  ia = '0;
    logic [3:0]  rng = '0;
    logic [3:0]  cid = '0;
    logic        alm = '0;
    logic [1:0]  hps;
    logic [1:0]  rps;
    logic [1:0]  slc;
    logic        scs;
    logic [4:0]  dctl;
    logic [31:0] seed = 32'hdf0b_c027;
    logic [31:0] v;
    logic [31:0] exq[$];
    logic [4:0]  dc[4] = '{5'h1a, 5'h1f, 5'h05, 5'h12};
    int          n_mismatch = 0;
    int          tests_run = 0;

    ashp_link_if link();
    ashp_device i_ashp_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .conv_result(res), .supply_alarm(sa),
        .input_alarm(ia), .range_code(rng), .chain_id(cid), .alarm_level(alm), .host_protocol_sel(hps),
        .read_protocol_sel(rps), .second_lane_cfg(slc), .sync_clock_source_sel(scs), .data_ctl(dctl), .link(link));
    ashp_host i_ashp_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(link));
    ashp_link_asserts i_ashp_link_asserts (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .convert_start_select_n(link.convert_start_select_n), .serial_clock(link.serial_clock),
        .serial_in(link.serial_in), .serial_out_lane0(link.serial_out_lane0),
        .shared_alarm_pin(link.shared_alarm_pin), .ready_strobe_out(link.ready_strobe_out),
        .host_protocol_sel(hps), .read_protocol_sel(rps), .second_lane_cfg(slc));

    always #4 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Flags stack below the result in fixed order, then the word is left-justified
    function automatic logic [31:0] exp_word(input logic [4:0] c);
        logic [63:0] a;
        int          n;
        a = 64'(res);
        if (c[CHAIN_BIT]) a = {a[59:0], cid};
        if (c[SUPPLY_BIT]) a = {a[61:0], sa};
        if (c[INPUT_BIT]) a = {a[61:0], ia};
        if (c[RANGE_BIT]) a = {a[59:0], rng};
        if (c[PARITY_BIT]) a = {a[61:0], ^res, ^a};
        n = 18 + 4 * c[0] + 2 * c[1] + 2 * c[2] + 4 * c[3] + 2 * c[4];
        return 32'(a << (32 - n));
    endfunction

    function automatic logic [31:0] cf(input logic [1:0] m, input logic [5:0] n, input logic [2:0] f);
        return {18'h0_0000, n, 3'h0, f, m};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Busy poll is bounded; the gap after it covers the port's synchroniser lag
    task automatic frame(input logic [31:0] cfg, input logic [31:0] tx);
        wreg(HREG_TX, tx);
        wreg(HREG_CFG, cfg);
        wreg(HREG_GO, '0);
        for (int i = 0; i < 500; i++) begin
            rreg(HREG_STAT);
            if (v[0] === 1'b0) break;
        end
        if (v[0] !== 1'b0) n_mismatch++;
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic cmd(input logic [31:0] cfg, input logic [7:0] r, input logic [15:0] d);
        frame(cfg, {CMD_WRITE, r, d});
    endtask

    task automatic rdw(input logic [31:0] cfg, input logic [31:0] want, input logic [31:0] tx = 32'h0000_0000);
        frame(cfg, tx);
        exq.push_back(want);
        rreg(HREG_RX);
    endtask

    task automatic rst();
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        {res, sa, ia, rng, cid, alm} <= 31'(xs());
        #1 chk(32'({hps, rps, slc, scs, dctl}), '0);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        if (rx_q)
            chk(rdata, exq.pop_front());
        rx_q <= rd && addr == HREG_RX;
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        give_verdict();
    end

    initial begin
        for (int m = 0; m < 4; m++) begin
            rst();
            cmd(cf(2'h0, 6'h20, 3'h0), REG_HOST_IN, 16'(m));
            chk(32'(hps), 32'(m));
            cmd(cf(2'(m), 6'h20, 3'h0), REG_DATA_CTL, 16'(dc[m]));
            chk(32'(dctl), 32'(dc[m]));
            rdw(cf(2'(m), 6'h20, 3'h0), exp_word(dc[m]));
        end
        // Forty clocks: the host's first byte comes back behind the word
        rdw(cf(2'h3, 6'h28, 3'h0), (exp_word(dc[3]) << 8) | 32'h0000_00a5, 32'ha500_0000);
        rdw(cf(2'h3, 6'h08, 3'h0), exp_word(dc[3]) >> 24);
        // A full command split over two short frames must still be refused
        cmd(cf(2'h3, 6'h10, 3'h0), REG_DATA_CTL, 16'h0000);
        frame(cf(2'h3, 6'h10, 3'h0), 32'h0000_0000);
        chk(32'(dctl), 32'(dc[3]));
        cmd(cf(2'h3, 6'h20, 3'h0), REG_OUT_CTL, 16'h0300);
        chk(32'(slc), 32'(DUAL_LANE));
        rdw(cf(2'h3, 6'h10, 3'h1), exp_word(dc[3]));
        cmd(cf(2'h3, 6'h20, 3'h0), REG_OUT_CTL, 16'h0001);
        chk(32'(rps), 32'h0000_0001);
        rdw(cf(2'h3, 6'h20, 3'h2), exp_word(dc[3]));
        cmd(cf(2'h3, 6'h20, 3'h0), REG_OUT_CTL, 16'h0041);
        chk(32'(scs), 32'h0000_0001);
        rdw(cf(2'h3, 6'h20, 3'h6), exp_word(dc[3]));
        give_verdict();
    end
endmodule
